// ### design/pco_operation_command_logic.sv
/*
 * Run-time command and priority logic of an eight-level interrupt
 * controller: mask register, in-service register, nested or rotating
 * priority, end-of-interrupt forms, set priority and special mask mode.
 * Assumes the write port, acknowledge pulses, request register and
 * initialization strobes all come from logic on core_clk.
 */
//
// Contract
// - Address and bits 4:3 decode the command word
// - Mask bit one masks only its line
// - Enable bit gates special mask mode changes
// - Fully nested, level 0 highest after initialization
// - Acknowledge picks highest request, sets in-service bit
// - In-service bit blocks equal and lower levels
// - Automatic end-of-interrupt on final acknowledge pulse
// - Automatic mode holds until fourth word rewritten
// - Non-specific end clears highest in-service bit
// - Specific end clears only the coded level
// - Rotating end clears and makes level lowest
// - Rotate-on-automatic flag set and cleared by word
// - Set priority changes order, keeps in-service bits
// - Rotate on specific end clears and reorders
// - Level bits used only with select-level set
// - Special mask mode ignores in-service bits
// - Special mask non-specific end skips masked levels
// - First init word resets mask, order, special mask, read select
// - Mode word stores status read selection
`timescale 1ns/1ns
`include "pco_regs.svh"

module pco_operation_command_logic (
  input wire logic core_clk,            // System clock
  input wire logic reset_n,             // Asynchronous reset, active low
  input wire logic clkEn,               // Clock enable, freezes state when low
  input wire logic wrEn,                // Command write strobe, one cycle
  input wire logic cmdSelAddr,          // Command select address bit
  input wire logic [7:0] wrData,        // Command write data
  input wire logic firstInitWr,         // First init word written, one cycle
  input wire logic autoEoiEn,           // Automatic end mode from fourth word
  input wire logic cpuMode16,           // One: two acknowledge pulses
  input wire logic [7:0] requestReg,    // Request register from capture logic
  input wire logic ackStart,            // Leading edge of first acknowledge
  input wire logic ackEnd,              // Trailing edge of any acknowledge
  output logic intOut,                  // Interrupt output, registered
  output logic [7:0] maskRegOut,        // Mask register for status reads
  output logic [7:0] inServiceOut,      // In-service register
  output logic [2:0] lowestLvlOut,      // Current lowest priority level
  output logic [2:0] vectorLevel,       // Level acknowledged
  output logic vectorValid,             // Vector level valid in a sequence
  output logic [7:0] irrClear,          // Request bit to clear, pulse
  output logic specialMaskOut,          // Special mask mode flag
  output logic rotAeoiOut,              // Rotate on automatic end flag
  output logic readSelOut,              // Status read selects in-service
  output logic pollReq,                 // Poll command issued, pulse
  output logic readRegCmd               // Read register command, pulse
);

  // Registered state and its next value
  pco_pkg::pco_state_t state_ff;
  pco_pkg::pco_state_t nxt_state;

  // Rank of a level: zero is highest priority, seven lowest
  function automatic logic [2:0] rankOf(input logic [2:0] lvl,
                                        input logic [2:0] low);
    rankOf = 3'(lvl - low - 3'h1);
  endfunction : rankOf

  // Highest-priority set bit of a vector; msb of result is found flag
  function automatic logic [3:0] pickTop(input logic [7:0] vec,
                                         input logic [2:0] low);
    logic [2:0] lvl;
    pickTop = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      lvl = 3'(low + 3'h1 + 3'(i));
      if (vec[lvl]) begin
        pickTop = {1'b1, lvl};
      end
    end
  endfunction : pickTop

  // Non-specific end target; masked levels skipped in special mask mode
  function automatic logic [3:0] nsTarget(input pco_pkg::pco_state_t s);
    logic [7:0] cand;
    cand = s.specialMask ? (s.inService & ~s.maskReg) : s.inService;
    nsTarget = pickTop(cand, s.lowestLvl);
  endfunction : nsTarget

  // Requests allowed to interrupt under the current mask and nesting
  logic [7:0] pending;   // Unmasked requests
  logic [7:0] eligible;  // Requests that may raise the interrupt
  logic [3:0] isrTop;    // Highest in-service level
  logic [3:0] reqTop;    // Highest eligible request
  logic [2:0] cmdBits;   // Rotate, select-level, end bits of the word
  logic [2:0] cmdLvl;    // Level code bits of the word
  logic [3:0] eoiTgt;    // Non-specific end target
  logic [1:0] finalCnt;  // Pulses in one acknowledge sequence

  // Eligibility: the mask acts per line; nesting blocks equal or lower
  always_comb begin
    pending = requestReg & ~state_ff.maskReg;
    isrTop = pickTop(state_ff.inService, state_ff.lowestLvl);
    eligible = 8'h00;
    for (int n = 0; n < 8; n++) begin
      if (state_ff.specialMask) begin
        eligible[n] = pending[n];
      end else begin
        eligible[n] = pending[n] && (!isrTop[3] ||
          rankOf(3'(n), state_ff.lowestLvl) < rankOf(isrTop[2:0], state_ff.lowestLvl));
      end
    end
    reqTop = pickTop(eligible, state_ff.lowestLvl);
  end

  // Field split and the acknowledge length
  always_comb begin
    cmdBits = {wrData[`PCO_PE_ROT], wrData[`PCO_PE_SL], wrData[`PCO_PE_EOI]};
    cmdLvl = wrData[`PCO_LVL_HI:`PCO_LVL_LO];
    eoiTgt = nsTarget(state_ff);
    finalCnt = cpuMode16 ? `PCO_ACK_FINAL_16 : `PCO_ACK_FINAL_8;
  end

  // Next state: writes first, so an acknowledge set wins over a clear
  always_comb begin
    nxt_state = state_ff;
    if (clkEn) begin
      // Pulses last one enabled cycle; a disabled cycle holds them too
      nxt_state.pollReq = 1'b0;
      nxt_state.readRegCmd = 1'b0;
      nxt_state.irrClear = 8'h00;
      // Command writes
      if (wrEn) begin
        if (cmdSelAddr == `PCO_ADDR_MASK) begin
          nxt_state.maskReg = wrData;
        end else begin
          case (wrData[`PCO_SEL_HI:`PCO_SEL_LO])
            `PCO_SEL_PRIO: begin
              // Level bits are read only in the select-level forms
              case (cmdBits)
                `PCO_CMD_NS_EOI: begin
                  if (eoiTgt[3]) begin
                    nxt_state.inService[eoiTgt[2:0]] = 1'b0;
                  end
                end
                `PCO_CMD_SP_EOI: begin
                  nxt_state.inService[cmdLvl] = 1'b0;
                end
                `PCO_CMD_ROT_NS_EOI: begin
                  if (eoiTgt[3]) begin
                    nxt_state.inService[eoiTgt[2:0]] = 1'b0;
                    nxt_state.lowestLvl = eoiTgt[2:0];
                  end
                end
                `PCO_CMD_SET_ROT_AUTOMATIC_END_OF_INTERRUPT: begin
                  nxt_state.rotAeoi = 1'b1;
                end
                `PCO_CMD_CLR_ROT_AUTOMATIC_END_OF_INTERRUPT: begin
                  nxt_state.rotAeoi = 1'b0;
                end
                `PCO_CMD_SET_PRIO: begin
                  nxt_state.lowestLvl = cmdLvl;
                end
                `PCO_CMD_ROT_SP_EOI: begin
                  nxt_state.inService[cmdLvl] = 1'b0;
                  nxt_state.lowestLvl = cmdLvl;
                end
                `PCO_CMD_NOP: begin
                  nxt_state.rotAeoi = state_ff.rotAeoi;
                end
                default: begin
                  nxt_state.rotAeoi = state_ff.rotAeoi;
                end
              endcase
            end
            `PCO_SEL_MODE: begin
              // Mode bit counts only with its enable bit
              if (wrData[`PCO_MM_MASK_MODE_WRITE_ENABLE]) begin
                nxt_state.specialMask = wrData[`PCO_MM_SMM];
              end
              if (wrData[`PCO_MM_RR]) begin
                nxt_state.readSel = wrData[`PCO_MM_RIS];
              end
              nxt_state.pollReq = wrData[`PCO_MM_POLL];
              nxt_state.readRegCmd = wrData[`PCO_MM_RR];
            end
            default: begin
              // Initialization words belong to the init sequencer
              nxt_state.pollReq = 1'b0;
            end
          endcase
        end
      end
      // Acknowledge sequence
      case (state_ff.phase)
        pco_pkg::PCO_IDLE: begin
          if (ackStart) begin
            nxt_state.phase = pco_pkg::PCO_ACK;
            nxt_state.ackCnt = 2'h0;
            nxt_state.vectorValid = 1'b1;
            if (reqTop[3]) begin
              // Set after any end command of this cycle
              nxt_state.ackLevel = reqTop[2:0];
              nxt_state.inService[reqTop[2:0]] = 1'b1;
              nxt_state.irrClear[reqTop[2:0]] = 1'b1;
            end else begin
              // Request vanished: default lowest line, no in-service bit
              nxt_state.ackLevel = `PCO_DEFAULT_LVL;
            end
          end
        end
        pco_pkg::PCO_ACK: begin
          if (ackEnd) begin
            nxt_state.ackCnt = 2'(state_ff.ackCnt + 2'h1);
            if (2'(state_ff.ackCnt + 2'h1) == finalCnt) begin
              nxt_state.phase = pco_pkg::PCO_IDLE;
              nxt_state.vectorValid = 1'b0;
              // Mode level from the fourth word applies to every sequence
              if (autoEoiEn && eoiTgt[3]) begin
                nxt_state.inService[eoiTgt[2:0]] = 1'b0;
                if (state_ff.rotAeoi) begin
                  nxt_state.lowestLvl = eoiTgt[2:0];
                end
              end
            end
          end
        end
        default: begin
          nxt_state.phase = pco_pkg::PCO_IDLE;
        end
      endcase
      // First init word overrides mask, order, special mask and read select written in the same cycle
      if (firstInitWr) begin
        nxt_state.maskReg = `PCO_MASK_RST;
        nxt_state.lowestLvl = `PCO_LOWEST_RST;
        nxt_state.specialMask = 1'b0;
        nxt_state.readSel = 1'b0;
        nxt_state.phase = pco_pkg::PCO_IDLE;
        nxt_state.vectorValid = 1'b0;
      end
      // Interrupt stays up while any eligible request is waiting
      nxt_state.intOut = reqTop[3];
    end
  end

  // State register; clock enable low holds everything
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= '{maskReg: `PCO_MASK_RST, inService: 8'h00,
                    lowestLvl: `PCO_LOWEST_RST, specialMask: 1'b0,
                    rotAeoi: 1'b0, readSel: 1'b0, pollReq: 1'b0,
                    readRegCmd: 1'b0, irrClear: 8'h00,
                    phase: pco_pkg::PCO_IDLE, ackCnt: 2'h0,
                    ackLevel: 3'h0, vectorValid: 1'b0, intOut: 1'b0};
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Outputs taken straight from the state register
  assign intOut = state_ff.intOut;
  assign maskRegOut = state_ff.maskReg;
  assign inServiceOut = state_ff.inService;
  assign lowestLvlOut = state_ff.lowestLvl;
  assign vectorLevel = state_ff.ackLevel;
  assign vectorValid = state_ff.vectorValid;
  assign irrClear = state_ff.irrClear;
  assign specialMaskOut = state_ff.specialMask;
  assign rotAeoiOut = state_ff.rotAeoi;
  assign readSelOut = state_ff.readSel;
  assign pollReq = state_ff.pollReq;
  assign readRegCmd = state_ff.readRegCmd;

  // Helper terms for the checks below
  logic quiet;     // Enabled cycle with no init word
  logic prioWr;    // Priority word write
  logic modeWr;    // Mode word write
  assign quiet = clkEn && !firstInitWr;
  assign prioWr = wrEn && cmdSelAddr != `PCO_ADDR_MASK &&
                  wrData[`PCO_SEL_HI:`PCO_SEL_LO] == `PCO_SEL_PRIO;
  assign modeWr = wrEn && cmdSelAddr != `PCO_ADDR_MASK &&
                  wrData[`PCO_SEL_HI:`PCO_SEL_LO] == `PCO_SEL_MODE;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // Final acknowledge pulse of a sequence
  sequence finalPulse;
    quiet && state_ff.phase == pco_pkg::PCO_ACK && ackEnd &&
      2'(state_ff.ackCnt + 2'h1) == finalCnt;
  endsequence
  // Start of a sequence with a real request
  sequence realStart;
    quiet && state_ff.phase == pco_pkg::PCO_IDLE && ackStart && reqTop[3];
  endsequence

  mask_write_a: assert property (
    quiet && wrEn && cmdSelAddr == `PCO_ADDR_MASK |=> maskRegOut == $past(wrData))
    else $error("mask word not stored");
  smm_gate_a: assert property (
    quiet && modeWr |=> specialMaskOut ==
    ($past(wrData[`PCO_MM_MASK_MODE_WRITE_ENABLE]) ? $past(wrData[`PCO_MM_SMM]) : $past(specialMaskOut)))
    else $error("special mask mode gate wrong");
  ack_sets_isr_a: assert property (
    realStart |=> inServiceOut[vectorLevel] && vectorLevel == $past(reqTop[2:0]) &&
    irrClear != 8'h00) else $error("acknowledge did not set in-service bit");
  nested_block_a: assert property (
    clkEn && !specialMaskOut && isrTop[3] && pending == (8'h01 << isrTop[2:0])
    |=> !intOut) else $error("same level not inhibited");
  auto_eoi_a: assert property (
    finalPulse ##0 (autoEoiEn && eoiTgt[3] && !wrEn)
    |=> !inServiceOut[$past(eoiTgt[2:0])] && !vectorValid)
    else $error("automatic end missing");
  // An automatic rotation at a final pulse may move the order in the same cycle
  spec_eoi_a: assert property (
    quiet && prioWr && cmdBits == `PCO_CMD_SP_EOI && !ackStart && !ackEnd
    |=> !inServiceOut[$past(cmdLvl)] && lowestLvlOut == $past(lowestLvlOut))
    else $error("specific end wrong");
  rot_eoi_a: assert property (
    quiet && prioWr && cmdBits == `PCO_CMD_ROT_NS_EOI && eoiTgt[3] &&
    state_ff.phase == pco_pkg::PCO_IDLE |=> lowestLvlOut == $past(eoiTgt[2:0]))
    else $error("rotating end wrong");
  set_prio_a: assert property (
    quiet && prioWr && cmdBits == `PCO_CMD_SET_PRIO && !ackStart && !ackEnd
    |=> lowestLvlOut == $past(cmdLvl) && inServiceOut == $past(inServiceOut))
    else $error("set priority wrong");
  init_reset_a: assert property (
    clkEn && firstInitWr |=> maskRegOut == `PCO_MASK_RST &&
    lowestLvlOut == `PCO_LOWEST_RST && !specialMaskOut && !readSelOut)
    else $error("first init word reset wrong");

  // Further command forms and the clock enable hold
  ns_eoi_a: assert property (
    quiet && prioWr && cmdBits == `PCO_CMD_NS_EOI && eoiTgt[3] && !ackStart && !ackEnd
    |=> !inServiceOut[$past(eoiTgt[2:0])] && lowestLvlOut == $past(lowestLvlOut))
    else $error("non-specific end wrong");
  smm_keep_a: assert property (
    quiet && prioWr && cmdBits == `PCO_CMD_NS_EOI && specialMaskOut && !ackEnd
    |=> (inServiceOut & maskRegOut) == ($past(inServiceOut) & $past(maskRegOut)))
    else $error("masked level cleared in special mask mode");
  poll_fwd_a: assert property (
    quiet && modeWr |=> pollReq == $past(wrData[`PCO_MM_POLL]) &&
    readRegCmd == $past(wrData[`PCO_MM_RR]) && maskRegOut == $past(maskRegOut))
    else $error("mode word bits not forwarded");
  idle_word_a: assert property (
    quiet && prioWr && cmdBits == `PCO_CMD_NOP && !ackStart && !ackEnd
    |=> $stable(inServiceOut) && $stable(lowestLvlOut) && $stable(rotAeoiOut))
    else $error("idle priority word changed state");
  freeze_hold_a: assert property ( // Clock enable low holds mask, in-service, order, poll, clear, vector valid and interrupt
    !clkEn |=> $stable(maskRegOut) && $stable(inServiceOut) && $stable(lowestLvlOut) &&
    $stable(pollReq) && $stable(irrClear) && $stable(vectorValid) && $stable(intOut))
    else $error("state moved with clock enable low");

endmodule : pco_operation_command_logic

// ### design/pco_regs.svh
/*
 * Command word layout, reset values and acknowledge counts for the
 * operation command logic of the eight-level interrupt controller.
 * Assumes it is included by bare name from design files only.
 */
`ifndef PCO_REGS_SVH
`define PCO_REGS_SVH

// Command select address value that marks a mask word
`define PCO_ADDR_MASK 1'h1
// Selector field of a command word on the low address
`define PCO_SEL_HI 4
`define PCO_SEL_LO 3
`define PCO_SEL_PRIO 2'h0
`define PCO_SEL_MODE 2'h1
// Priority / end-of-interrupt word fields
`define PCO_PE_ROT 7
`define PCO_PE_SL 6
`define PCO_PE_EOI 5
`define PCO_LVL_HI 2
`define PCO_LVL_LO 0
// Rotate, select-level, end-of-interrupt combinations
`define PCO_CMD_CLR_ROT_AUTOMATIC_END_OF_INTERRUPT 3'h0
`define PCO_CMD_NS_EOI 3'h1
`define PCO_CMD_NOP 3'h2
`define PCO_CMD_SP_EOI 3'h3
`define PCO_CMD_SET_ROT_AUTOMATIC_END_OF_INTERRUPT 3'h4
`define PCO_CMD_ROT_NS_EOI 3'h5
`define PCO_CMD_SET_PRIO 3'h6
`define PCO_CMD_ROT_SP_EOI 3'h7
// Mask mode / read word fields
`define PCO_MM_MASK_MODE_WRITE_ENABLE 6
`define PCO_MM_SMM 5
`define PCO_MM_POLL 2
`define PCO_MM_RR 1
`define PCO_MM_RIS 0
// Reset and initialization values
`define PCO_MASK_RST 8'h00
`define PCO_LOWEST_RST 3'h7
`define PCO_DEFAULT_LVL 3'h7
// Acknowledge pulses per sequence
`define PCO_ACK_FINAL_8 2'h3
`define PCO_ACK_FINAL_16 2'h2

`endif

// ### design/pco_pkg.sv
/*
 * Types of the operation command logic: acknowledge phase and the
 * packed state record. Assumes the eight request levels of the block.
 */
package pco_pkg;

  // Acknowledge sequence phase
  typedef enum logic {
    PCO_IDLE,
    PCO_ACK
  } pco_phase_t;

  // Whole state of the block, registered as one word
  typedef struct packed {
    logic [7:0] maskReg;     // Mask register
    logic [7:0] inService;   // In-service register
    logic [2:0] lowestLvl;   // Level holding lowest priority
    logic specialMask;       // Special mask mode active
    logic rotAeoi;           // Rotate on automatic end-of-interrupt
    logic readSel;           // Status read picks in-service register
    logic pollReq;           // Poll bit of last mode word, pulse
    logic readRegCmd;        // Read-register bit of last mode word, pulse
    logic [7:0] irrClear;    // Request bit to drop on acknowledge, pulse
    pco_phase_t phase;       // Acknowledge phase
    logic [1:0] ackCnt;      // Acknowledge pulses finished so far
    logic [2:0] ackLevel;    // Level chosen on the first acknowledge
    logic vectorValid;       // Chosen level may be presented
    logic intOut;            // Interrupt output to the processor
  } pco_state_t;

endpackage : pco_pkg

// ### bench/pco_host_model.sv
/* Host processor model: command writes and acknowledge pulses.
   Assumes the controller samples every strobe on the rising core_clk edge. */
`timescale 1ns/1ns

module pco_host_model (
  input wire logic core_clk,    // System clock
  output logic wrEn,            // Command write strobe
  output logic cmdSelAddr,      // Command select address
  output logic [7:0] wrData,    // Command data
  output logic ackStart,        // Leading edge of first acknowledge
  output logic ackEnd           // Trailing edge of an acknowledge
);
  // Idle bus from time zero
  initial begin
    wrEn = 1'h0;
    cmdSelAddr = 1'h0;
    wrData = 8'h00;
    ackStart = 1'h0;
    ackEnd = 1'h0;
  end

  // One write, held until the taking edge
  task automatic wr(input logic a, input logic [7:0] d);
    @(posedge core_clk);
    wrEn <= 1'h1;
    cmdSelAddr <= a;
    wrData <= d;
    @(posedge core_clk);
    wrEn <= 1'h0;
    wrData <= ~d;  // Released bus must not keep the old byte
  endtask : wr

  // End command closing a service routine; a single controller needs one
  task automatic end_of_interrupt_bit(input logic [7:0] cmd);
    wr(1'h0, cmd);
  endtask : end_of_interrupt_bit

  // First acknowledge pulse
  task automatic ack_start();
    @(posedge core_clk);
    ackStart <= 1'h1;
    @(posedge core_clk);
    ackStart <= 1'h0;
  endtask : ack_start

  // Remaining acknowledge pulses, one gap cycle each
  task automatic ack_end(input int n);
    repeat (n) begin
      @(posedge core_clk);
      ackEnd <= 1'h1;
      @(posedge core_clk);
      ackEnd <= 1'h0;
    end
  endtask : ack_end
endmodule : pco_host_model

// ### bench/tb_top.sv
/* Self-checking bench of the operation command logic.
   Assumes the host model drives the write and acknowledge strobes. */
`timescale 1ns/1ns

module tb_top;
  typedef struct {string name; logic [7:0] exp;} pco_note_t;
  logic core_clk, reset_n, clkEn, firstInitWr, autoEoiEn, cpuMode16;
  logic wrEn, cmdSelAddr, ackStart, ackEnd;
  logic [7:0] wrData, requestReg, maskRegOut, inServiceOut, irrClear, got, rnd, rq;
  logic [2:0] lowestLvlOut, vectorLevel;
  logic intOut, vectorValid, specialMaskOut, rotAeoiOut, readSelOut, pollReq, readRegCmd;
  pco_note_t notes[$];  // Expected results, oldest first
  pco_note_t n;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;

  pco_host_model u_host (.core_clk(core_clk), .wrEn(wrEn), .cmdSelAddr(cmdSelAddr),
    .wrData(wrData), .ackStart(ackStart), .ackEnd(ackEnd));

  pco_operation_command_logic u_dut (.core_clk(core_clk), .reset_n(reset_n), .clkEn(clkEn),
    .wrEn(wrEn), .cmdSelAddr(cmdSelAddr), .wrData(wrData), .firstInitWr(firstInitWr),
    .autoEoiEn(autoEoiEn), .cpuMode16(cpuMode16), .requestReg(requestReg),
    .ackStart(ackStart), .ackEnd(ackEnd), .intOut(intOut), .maskRegOut(maskRegOut),
    .inServiceOut(inServiceOut), .lowestLvlOut(lowestLvlOut), .vectorLevel(vectorLevel),
    .vectorValid(vectorValid), .irrClear(irrClear), .specialMaskOut(specialMaskOut),
    .rotAeoiOut(rotAeoiOut), .readSelOut(readSelOut), .pollReq(pollReq),
    .readRegCmd(readRegCmd));

  // 100 MHz clock
  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end

  // Pseudo-random bytes for mask words
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  // Output picked by the name of a note
  function automatic logic [7:0] seen(input string s);
    case (s)
      "mask": return maskRegOut;
      "insvc": return inServiceOut;
      "lowest": return {5'h00, lowestLvlOut};
      "vector": return {4'h0, vectorValid, vectorLevel};
      "irq": return {7'h00, intOut};
      "clear": return irrClear;
      "flags": return {3'h0, specialMaskOut, rotAeoiOut, readSelOut, pollReq, readRegCmd};
      default: return 8'hFF;
    endcase
  endfunction : seen

  task automatic note(input string s, input logic [7:0] v);
    notes.push_back('{s, v});
  endtask : note

  task automatic settle(input int c);
    repeat (c) @(posedge core_clk);
  endtask : settle

  task automatic finish_test();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  // Watcher: outputs are settled at the falling edge, compare every pending note
  always @(negedge core_clk) begin
    while (notes.size() > 0) begin
      n = notes.pop_front();
      got = seen(n.name);
      n_checks++;
      if (got !== n.exp) begin
        miscompares++;
        $display("unexpected %s: expected %h seen %h", n.name, n.exp, got);
      end
    end
  end

  // Hang guard, far above the roughly 150 cycles the run needs
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      finish_test();
    end
  end

  initial begin
    reset_n = 1'h0;
    clkEn = 1'h1;
    firstInitWr = 1'h0;
    autoEoiEn = 1'h0;
    cpuMode16 = 1'h1;
    requestReg = 8'h00;
    rnd = 8'h4D;
    settle(12);
    reset_n <= 1'h1;
    settle(1);
    note("mask", 8'h00);
    note("insvc", 8'h00);
    note("lowest", 8'h07);
    note("flags", 8'h00);
    // Random mask words and requests: only unmasked lines raise the output
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      u_host.wr(1'h1, rnd);
      note("mask", rnd);
      rq = i[0] ? rnd : lfsr(rnd);
      requestReg <= rq;
      settle(2);
      note("irq", {7'h00, |(rq & ~rnd)});
    end
    // Masked level 3 is silent, unmasked level 4 still served
    u_host.wr(1'h1, 8'h08);
    requestReg <= 8'h08;
    settle(3);
    note("irq", 8'h00);
    requestReg <= 8'h18;
    settle(3);
    note("irq", 8'h01);
    u_host.ack_start();
    note("vector", 8'h0C);
    note("clear", 8'h10);
    note("insvc", 8'h10);
    // Level 4 keeps requesting while in service: an equal level waits
    requestReg <= 8'h10;
    u_host.ack_end(2);
    note("vector", 8'h04);
    note("irq", 8'h00);
    u_host.wr(1'h1, 8'h00);
    // Nesting: lower level blocked, higher level passes
    requestReg <= 8'h20;
    settle(3);
    note("irq", 8'h00);
    requestReg <= 8'h22;
    settle(3);
    note("irq", 8'h01);
    u_host.ack_start();
    note("vector", 8'h09);
    note("insvc", 8'h12);
    requestReg <= 8'h20;
    u_host.ack_end(2);
    note("insvc", 8'h12);
    u_host.end_of_interrupt_bit(8'h24);
    note("insvc", 8'h10);
    u_host.end_of_interrupt_bit(8'h64);
    note("insvc", 8'h00);
    // Rotating end, set priority, idle and refused words
    u_host.ack_start();
    note("vector", 8'h0D);
    requestReg <= 8'h00;
    u_host.ack_end(2);
    u_host.wr(1'h0, 8'hC2);
    note("lowest", 8'h02);
    note("insvc", 8'h20);
    u_host.end_of_interrupt_bit(8'hA0);
    note("insvc", 8'h00);
    note("lowest", 8'h05);
    u_host.wr(1'h0, 8'hC2);
    u_host.wr(1'h0, 8'h47);
    note("lowest", 8'h02);
    note("flags", 8'h00);
    u_host.wr(1'h0, {rnd[7:5], 2'h3, rnd[2:0]});
    note("lowest", 8'h02);
    requestReg <= 8'h11;
    u_host.ack_start();
    note("vector", 8'h0C);
    requestReg <= 8'h01;
    u_host.ack_end(2);
    u_host.end_of_interrupt_bit(8'hE4);
    note("insvc", 8'h00);
    note("lowest", 8'h04);
    // Automatic end with rotation, three pulses then two
    u_host.wr(1'h0, 8'h80);
    note("flags", 8'h08);
    autoEoiEn <= 1'h1;
    cpuMode16 <= 1'h0;
    u_host.ack_start();
    note("vector", 8'h08);
    requestReg <= 8'h40;
    u_host.ack_end(2);
    note("insvc", 8'h01);
    u_host.ack_end(1);
    note("insvc", 8'h00);
    note("lowest", 8'h00);
    cpuMode16 <= 1'h1;
    u_host.ack_start();
    note("vector", 8'h0E);
    requestReg <= 8'h00;
    u_host.ack_end(2);
    note("insvc", 8'h00);
    note("lowest", 8'h06);
    u_host.wr(1'h0, 8'h00);
    note("flags", 8'h00);
    autoEoiEn <= 1'h0;
    u_host.wr(1'h0, 8'hC7);
    // Special mask mode: set with its enable bit, in-service ignored, masked level kept
    u_host.wr(1'h0, 8'h68);
    note("flags", 8'h10);
    u_host.wr(1'h0, 8'h28);
    note("flags", 8'h10);
    requestReg <= 8'h04;
    u_host.ack_start();
    note("vector", 8'h0A);
    requestReg <= 8'h08;
    u_host.ack_end(2);
    settle(3);
    note("irq", 8'h01);
    u_host.wr(1'h1, 8'h0C);
    settle(3);
    note("irq", 8'h00);
    u_host.end_of_interrupt_bit(8'h20);
    note("insvc", 8'h04);
    u_host.end_of_interrupt_bit(8'h62);
    note("insvc", 8'h00);
    u_host.wr(1'h0, 8'h48);
    note("flags", 8'h00);
    requestReg <= 8'h00;
    // Read select and poll bits
    u_host.wr(1'h0, 8'h0B);
    note("flags", 8'h05);
    note("mask", 8'h0C);
    u_host.wr(1'h0, 8'h0C);
    clkEn <= 1'h0;
    note("flags", 8'h06);
    // Clock enable low: a write is lost and the poll pulse is held
    u_host.wr(1'h1, rnd);
    note("mask", 8'h0C);
    note("flags", 8'h06);
    clkEn <= 1'h1;
    u_host.wr(1'h0, 8'h0A);
    note("flags", 8'h01);
    // First init word restores mask, order, special mask mode and read select
    u_host.wr(1'h0, 8'hC3);
    u_host.wr(1'h0, 8'h6B);
    u_host.wr(1'h1, 8'hFF);
    firstInitWr <= 1'h1;
    settle(1);
    firstInitWr <= 1'h0;
    note("mask", 8'h00);
    note("lowest", 8'h07);
    note("flags", 8'h00);
    // Reset in mid-run while a level is in service
    requestReg <= 8'h01;
    u_host.ack_start();
    note("insvc", 8'h01);
    settle(1);
    reset_n <= 1'h0;
    settle(2);
    note("insvc", 8'h00);
    note("vector", 8'h00);
    note("irq", 8'h00);
    reset_n <= 1'h1;
    settle(1);
    note("lowest", 8'h07);
    note("mask", 8'h00);
    settle(2);
    finish_test();
  end
endmodule : tb_top
